// ===== core/pscm_top.sv
`timescale 1ns/1ps
module pscm_top #(
  parameter int MAKER_LEN = 3,
  // Arbitrary neutral identity text
  parameter logic [8*MAKER_LEN-1:0] MAKER_STR = "ACM",
  parameter int MODEL_LEN = 5,
  // Arbitrary neutral identity text
  parameter logic [8*MODEL_LEN-1:0] MODEL_STR = "PSQ01"
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_PAGE_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic [4:0] CMD_INDEX_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  input wire logic [1:0] CH_ON_REQ_IN,
  input wire logic [1:0] VOUT_ABOVE_UV_IN,
  input wire logic [1:0] VOUT_DECAYED_IN,
  input wire logic [15:0] EV_VOUT_IN,
  input wire logic [15:0] EV_IOUT_IN,
  input wire logic [15:0] EV_TEMP_IN,
  input wire logic [15:0] EV_MFR_IN,
  input wire logic [7:0] EV_INPUT_IN,
  input wire logic [7:0] EV_CML_IN,
  input wire logic [15:0] VIN_IN,
  input wire logic [15:0] IIN_IN,
  input wire logic [31:0] VOUT_IN,
  input wire logic [31:0] IOUT_IN,
  input wire logic [31:0] TEMP_EXT_IN,
  input wire logic [15:0] TEMP_DIE_IN,
  input wire logic [31:0] FREQ_IN,
  input wire logic [31:0] POUT_IN,
  input wire logic [15:0] PIN_IN,
  output logic RSP_VALID_OUT,
  output logic RSP_ERR_OUT,
  output logic [15:0] RSP_DATA_OUT,
  output logic [1:0] RAIL_EN_OUT,
  output logic [1:0] RISING_OUT,
  output logic [1:0] FALLING_OUT,
  output logic [31:0] CAL_TEMP_OUT
);

  //----------------------------------------------------------------
  // Parameter checks
  //----------------------------------------------------------------
  if (MAKER_LEN < 1 || MAKER_LEN > 31) begin : g_bad_maker
    $error("maker string length out of range");
  end
  if (MODEL_LEN < 1 || MODEL_LEN > 31) begin : g_bad_model
    $error("model string length out of range");
  end

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  // Byte k of a block read: 0 is the count, then text MSB first
  function automatic logic [7:0] str_byte(input logic [4:0] k,
      input logic [247:0] s, input int len);
    str_byte = 8'h0;
    if (k == 5'h0) begin
      str_byte = 8'(len);
    end else if (int'(k) <= len) begin
      str_byte = s[8*(len-int'(k)) +: 8];
    end
  endfunction : str_byte

  pscm_pkg::pscm_state_t r;
  pscm_pkg::pscm_state_t next_r;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic ch;
    logic [1:0] sel;
    logic [7:0] sbyte;
    logic [15:0] sword;
    logic [1:0][7:0] clr_vout;
    logic [1:0][7:0] clr_iout;
    logic [1:0][7:0] clr_temp;
    logic [1:0][7:0] clr_mfr;
    logic [7:0] clr_input;
    logic [7:0] clr_cml;
    logic [1:0][7:0] set_vout;
    logic bad_cmd;
    logic wr;
    tick = 1'b0;
    ch = 1'b0;
    sel = 2'b00;
    sbyte = 8'h0;
    sword = 16'h0;
    clr_vout = '0;
    clr_iout = '0;
    clr_temp = '0;
    clr_mfr = '0;
    clr_input = 8'h0;
    clr_cml = 8'h0;
    set_vout = '0;
    bad_cmd = 1'b0;
    wr = CMD_VALID_IN & CMD_WRITE_IN;
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_err = 1'b0;

    // Tick prescaler shared by all sequencing timers
    if (r.pre == 10'(pscm_pkg::TICK_CYC - 1)) begin
      next_r.pre = 10'h0;
      tick = 1'b1;
    end else begin
      next_r.pre = r.pre + 10'h1;
    end

    // Temperature compensation follows the external sensor only
    next_r.cal_temp = TEMP_EXT_IN;

    // Page select: page 0, page 1 or both
    ch = CMD_PAGE_IN[0];
    sel[0] = (CMD_PAGE_IN == 8'h00) || (CMD_PAGE_IN == pscm_pkg::PAGE_ALL);
    sel[1] = (CMD_PAGE_IN == 8'h01) || (CMD_PAGE_IN == pscm_pkg::PAGE_ALL);

    // Summary bits of the read channel
    sbyte[pscm_pkg::SB_OFF] = ~r.rail_en[ch];
    sbyte[pscm_pkg::SB_VOUT_OV] = r.st_vout[ch][pscm_pkg::VOUT_OV_BIT];
    sbyte[pscm_pkg::SB_IOUT_OC] = r.st_iout[ch][pscm_pkg::IOUT_OC_BIT];
    sbyte[pscm_pkg::SB_VIN_UV] = r.st_input[pscm_pkg::INPUT_UV_BIT];
    sbyte[pscm_pkg::SB_TEMP] = |r.st_temp[ch];
    sbyte[pscm_pkg::SB_CML] = |r.st_cml;
    sword = {8'h0, sbyte};
    sword[pscm_pkg::SW_VOUT] = |r.st_vout[ch];
    sword[pscm_pkg::SW_IOUT] = |r.st_iout[ch];
    sword[pscm_pkg::SW_INPUT] = |r.st_input;
    sword[pscm_pkg::SW_MFR] = |r.st_mfr[ch];
    sword[pscm_pkg::SW_PG_N] = (r.seq[ch] != pscm_pkg::SEQ_ON);

    // Command decode: writes to settings, reads of everything
    if (CMD_VALID_IN) begin
      next_r.rsp_valid = 1'b1;
      next_r.rsp_data = 16'h0;
      unique case (CMD_CODE_IN)
        pscm_pkg::CMD_TON_DLY: begin
          next_r.rsp_data = r.ton_dly[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.ton_dly[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_ON_RAMP: begin
          next_r.rsp_data = r.on_ramp[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.on_ramp[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_TON_MAX: begin
          next_r.rsp_data = r.ton_max[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.ton_max[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_TON_ACT: begin
          next_r.rsp_data = {8'h0, r.ton_act[ch]};
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.ton_act[c] = CMD_WDATA_IN[7:0];
          end
        end
        pscm_pkg::CMD_TOFF_DLY: begin
          next_r.rsp_data = r.toff_dly[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.toff_dly[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_OFF_RAMP: begin
          next_r.rsp_data = r.off_ramp[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.off_ramp[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_TOFF_WARN: begin
          next_r.rsp_data = r.toff_warn[ch];
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) next_r.toff_warn[c] = CMD_WDATA_IN;
          end
        end
        pscm_pkg::CMD_SUM_BYTE: next_r.rsp_data = {8'h0, sbyte};
        pscm_pkg::CMD_SUM_WORD: next_r.rsp_data = sword;
        pscm_pkg::CMD_ST_VOUT: begin
          next_r.rsp_data = {8'h0, r.st_vout[ch]};
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) clr_vout[c] = CMD_WDATA_IN[7:0];
          end
        end
        pscm_pkg::CMD_ST_IOUT: begin
          next_r.rsp_data = {8'h0, r.st_iout[ch]};
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) clr_iout[c] = CMD_WDATA_IN[7:0];
          end
        end
        pscm_pkg::CMD_ST_TEMP: begin
          next_r.rsp_data = {8'h0, r.st_temp[ch]};
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) clr_temp[c] = CMD_WDATA_IN[7:0];
          end
        end
        pscm_pkg::CMD_ST_MFR: begin
          next_r.rsp_data = {8'h0, r.st_mfr[ch]};
          for (int c = 0; c < 2; c++) begin
            if (wr && sel[c]) clr_mfr[c] = CMD_WDATA_IN[7:0];
          end
        end
        pscm_pkg::CMD_ST_INPUT: begin
          next_r.rsp_data = {8'h0, r.st_input};
          if (wr) clr_input = CMD_WDATA_IN[7:0];
        end
        pscm_pkg::CMD_ST_CML: begin
          next_r.rsp_data = {8'h0, r.st_cml};
          if (wr) clr_cml = CMD_WDATA_IN[7:0];
        end
        pscm_pkg::CMD_RD_VIN: next_r.rsp_data = VIN_IN;
        pscm_pkg::CMD_RD_IIN: next_r.rsp_data = IIN_IN;
        pscm_pkg::CMD_RD_VOUT: next_r.rsp_data = VOUT_IN[16*ch +: 16];
        pscm_pkg::CMD_RD_IOUT: next_r.rsp_data = IOUT_IN[16*ch +: 16];
        pscm_pkg::CMD_RD_FREQ: next_r.rsp_data = FREQ_IN[16*ch +: 16];
        pscm_pkg::CMD_RD_TEXT: next_r.rsp_data = TEMP_EXT_IN[16*ch +: 16];
        pscm_pkg::CMD_RD_TDIE: next_r.rsp_data = TEMP_DIE_IN;
        pscm_pkg::CMD_RD_POUT: next_r.rsp_data = POUT_IN[16*ch +: 16];
        pscm_pkg::CMD_RD_PIN: next_r.rsp_data = PIN_IN;
        pscm_pkg::CMD_REVISION: begin
          next_r.rsp_data = {8'h0, pscm_pkg::PROTO_REV};
        end
        pscm_pkg::CMD_MAKER_ID: begin
          next_r.rsp_data = {8'h0, str_byte(CMD_INDEX_IN,
              248'(MAKER_STR), MAKER_LEN)};
        end
        pscm_pkg::CMD_MODEL_ID: begin
          next_r.rsp_data = {8'h0, str_byte(CMD_INDEX_IN,
              248'(MODEL_STR), MODEL_LEN)};
        end
        pscm_pkg::CMD_VOUT_CEIL: next_r.rsp_data = pscm_pkg::VOUT_CEIL;
        default: bad_cmd = 1'b1;
      endcase
      // Writes to read-only codes are refused like unknown codes
      if (wr) begin
        unique case (CMD_CODE_IN)
          pscm_pkg::CMD_RD_VIN, pscm_pkg::CMD_RD_IIN, pscm_pkg::CMD_RD_VOUT,
          pscm_pkg::CMD_RD_IOUT, pscm_pkg::CMD_RD_TEXT, pscm_pkg::CMD_RD_TDIE,
          pscm_pkg::CMD_RD_FREQ, pscm_pkg::CMD_RD_POUT, pscm_pkg::CMD_RD_PIN,
          pscm_pkg::CMD_REVISION, pscm_pkg::CMD_MAKER_ID,
          pscm_pkg::CMD_MODEL_ID, pscm_pkg::CMD_VOUT_CEIL: bad_cmd = 1'b1;
          default: ;
        endcase
      end
      next_r.rsp_err = bad_cmd;
    end

    // Channel sequencers, each with its own timers
    for (int c = 0; c < 2; c++) begin
      if (tick && r.tmr[c] != 32'h0) begin
        next_r.tmr[c] = r.tmr[c] - 32'h1;
      end
      unique case (r.seq[c])
        pscm_pkg::SEQ_OFF: begin
          if (CH_ON_REQ_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_ON_DLY;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.ton_dly[c]);
          end
        end
        pscm_pkg::SEQ_ON_DLY: begin
          if (!CH_ON_REQ_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_OFF;
          end else if (r.tmr[c] == 32'h0) begin
            next_r.seq[c] = pscm_pkg::SEQ_RISE;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.on_ramp[c]);
            next_r.flt_tmr[c] = pscm_pkg::pscm_l11_ticks(r.ton_max[c]);
            next_r.flt_arm[c] = (r.ton_max[c][10:0] != 11'h0);
            next_r.uv_seen[c] = 1'b0;
          end
        end
        pscm_pkg::SEQ_RISE: begin
          if (!CH_ON_REQ_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_OFF_DLY;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.toff_dly[c]);
          end else if (r.tmr[c] == 32'h0) begin
            next_r.seq[c] = pscm_pkg::SEQ_ON;
          end
        end
        pscm_pkg::SEQ_ON: begin
          if (!CH_ON_REQ_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_OFF_DLY;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.toff_dly[c]);
          end
        end
        pscm_pkg::SEQ_OFF_DLY: begin
          if (CH_ON_REQ_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_ON;
          end else if (r.tmr[c] == 32'h0) begin
            next_r.seq[c] = pscm_pkg::SEQ_FALL;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.off_ramp[c]);
          end
        end
        pscm_pkg::SEQ_FALL: begin
          if (r.tmr[c] == 32'h0) begin
            next_r.seq[c] = pscm_pkg::SEQ_DECAY;
            next_r.tmr[c] = pscm_pkg::pscm_l11_ticks(r.toff_warn[c]);
          end
        end
        pscm_pkg::SEQ_DECAY: begin
          if (VOUT_DECAYED_IN[c]) begin
            next_r.seq[c] = pscm_pkg::SEQ_OFF;
          end else if (r.tmr[c] == 32'h0) begin
            set_vout[c][pscm_pkg::VOUT_TOFF_WARN_BIT] = 1'b1;
            next_r.seq[c] = pscm_pkg::SEQ_OFF;
          end
        end
        pscm_pkg::SEQ_FAULT: begin
          if (!CH_ON_REQ_IN[c]) next_r.seq[c] = pscm_pkg::SEQ_OFF;
        end
      endcase

      // Turn-on watchdog runs from the start of the rise
      if (r.seq[c] == pscm_pkg::SEQ_RISE || r.seq[c] == pscm_pkg::SEQ_ON) begin
        if (VOUT_ABOVE_UV_IN[c]) next_r.uv_seen[c] = 1'b1;
        if (tick && r.flt_tmr[c] != 32'h0) begin
          next_r.flt_tmr[c] = r.flt_tmr[c] - 32'h1;
        end
        if (r.flt_arm[c] && !r.uv_seen[c] && !VOUT_ABOVE_UV_IN[c] &&
            r.flt_tmr[c] == 32'h0) begin
          set_vout[c][pscm_pkg::VOUT_TON_MAX_BIT] = 1'b1;
          next_r.flt_arm[c] = 1'b0;
          if (r.ton_act[c][7:pscm_pkg::ACT_LSB] != 2'b00) begin
            next_r.seq[c] = pscm_pkg::SEQ_FAULT;
          end
        end
      end

      next_r.rail_en[c] = next_r.seq[c] inside {pscm_pkg::SEQ_RISE,
          pscm_pkg::SEQ_ON, pscm_pkg::SEQ_OFF_DLY, pscm_pkg::SEQ_FALL};
      next_r.rising[c] = (next_r.seq[c] == pscm_pkg::SEQ_RISE);
      next_r.falling[c] = (next_r.seq[c] == pscm_pkg::SEQ_FALL);
    end

    // Sticky status: a set in the clearing cycle wins
    for (int c = 0; c < 2; c++) begin
      next_r.st_vout[c] = (r.st_vout[c] & ~clr_vout[c]) |
          EV_VOUT_IN[8*c +: 8] | set_vout[c];
      next_r.st_iout[c] = (r.st_iout[c] & ~clr_iout[c]) | EV_IOUT_IN[8*c +: 8];
      next_r.st_temp[c] = (r.st_temp[c] & ~clr_temp[c]) | EV_TEMP_IN[8*c +: 8];
      next_r.st_mfr[c] = (r.st_mfr[c] & ~clr_mfr[c]) | EV_MFR_IN[8*c +: 8];
    end
    next_r.st_input = (r.st_input & ~clr_input) | EV_INPUT_IN;
    next_r.st_cml = (r.st_cml & ~clr_cml) | EV_CML_IN;
    next_r.st_cml[pscm_pkg::CML_BAD_CMD_BIT] =
        next_r.st_cml[pscm_pkg::CML_BAD_CMD_BIT] | bad_cmd;
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      r <= '0;
      r.ton_dly <= {2{pscm_pkg::RST_TON_DLY}};
      r.on_ramp <= {2{pscm_pkg::RST_ON_RAMP}};
      r.ton_max <= {2{pscm_pkg::RST_TON_MAX}};
      r.ton_act <= {2{pscm_pkg::RST_TON_ACT}};
      r.toff_dly <= {2{pscm_pkg::RST_TOFF_DLY}};
      r.off_ramp <= {2{pscm_pkg::RST_OFF_RAMP}};
      r.toff_warn <= {2{pscm_pkg::RST_TOFF_WARN}};
      r.seq <= '{default: pscm_pkg::SEQ_OFF};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign RSP_VALID_OUT = r.rsp_valid;
  assign RSP_ERR_OUT = r.rsp_err;
  assign RSP_DATA_OUT = r.rsp_data;
  assign RAIL_EN_OUT = r.rail_en;
  assign RISING_OUT = r.rising;
  assign FALLING_OUT = r.falling;
  assign CAL_TEMP_OUT = r.cal_temp;

endmodule : pscm_top

// ===== core/pscm_pkg.sv
// Notes on behaviour
// - Wait programmed turn-on delay before rising
// - Rise lasts the programmed per-channel rise time
// - Fault if no undervoltage crossing within limit
// - Turn-on fault handled per response byte
// - Wait programmed turn-off delay before falling
// - Fall lasts the programmed per-channel fall time
// - Warn if output not decayed after fall
// - Present one-byte and two-byte fault summaries
// - Report status by category, per channel except the shared input and communication status
// - External temperature drives temperature processing
// - Die temperature read-only, affects nothing else
// - Return telemetry words read-only
// - Protocol revision reads fixed 22h
// - Read-only output voltage ceiling, one fixed value for both channels
// - Maker and model strings by block read
// - Report calculated output and input power
package pscm_pkg;

  //----------------------------------------------------------------
  // Command codes
  //----------------------------------------------------------------
  localparam logic [7:0] CMD_TON_DLY = 8'h60;
  localparam logic [7:0] CMD_ON_RAMP = 8'h61;
  localparam logic [7:0] CMD_TON_MAX = 8'h62;
  localparam logic [7:0] CMD_TON_ACT = 8'h63;
  localparam logic [7:0] CMD_TOFF_DLY = 8'h64;
  localparam logic [7:0] CMD_OFF_RAMP = 8'h65;
  localparam logic [7:0] CMD_TOFF_WARN = 8'h66;
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_ST_VOUT = 8'h7a;
  localparam logic [7:0] CMD_ST_IOUT = 8'h7b;
  localparam logic [7:0] CMD_ST_INPUT = 8'h7c;
  localparam logic [7:0] CMD_ST_TEMP = 8'h7d;
  localparam logic [7:0] CMD_ST_CML = 8'h7e;
  localparam logic [7:0] CMD_ST_MFR = 8'h80;
  localparam logic [7:0] CMD_RD_VIN = 8'h88;
  localparam logic [7:0] CMD_RD_IIN = 8'h89;
  localparam logic [7:0] CMD_RD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_RD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_RD_TEXT = 8'h8d;
  localparam logic [7:0] CMD_RD_TDIE = 8'h8e;
  localparam logic [7:0] CMD_RD_FREQ = 8'h95;
  localparam logic [7:0] CMD_RD_POUT = 8'h96;
  localparam logic [7:0] CMD_RD_PIN = 8'h97;
  localparam logic [7:0] CMD_REVISION = 8'h98;
  localparam logic [7:0] CMD_MAKER_ID = 8'h99;
  localparam logic [7:0] CMD_MODEL_ID = 8'h9a;
  localparam logic [7:0] CMD_VOUT_CEIL = 8'ha5;
  localparam logic [7:0] PAGE_ALL = 8'hff;

  //----------------------------------------------------------------
  // Reset and fixed values
  //----------------------------------------------------------------
  localparam logic [15:0] RST_TON_DLY = 16'h8000;
  localparam logic [15:0] RST_ON_RAMP = 16'hd200;
  localparam logic [15:0] RST_TON_MAX = 16'hd280;
  localparam logic [7:0] RST_TON_ACT = 8'hb8;
  localparam logic [15:0] RST_TOFF_DLY = 16'h8000;
  localparam logic [15:0] RST_OFF_RAMP = 16'hd200;
  localparam logic [15:0] RST_TOFF_WARN = 16'hf258;
  localparam logic [7:0] PROTO_REV = 8'h22;
  localparam logic [15:0] VOUT_CEIL = 16'he000;

  //----------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------
  localparam int VOUT_TON_MAX_BIT = 2;
  localparam int VOUT_TOFF_WARN_BIT = 1;
  localparam int VOUT_OV_BIT = 7;
  localparam int IOUT_OC_BIT = 7;
  localparam int INPUT_UV_BIT = 4;
  localparam int CML_BAD_CMD_BIT = 7;
  localparam int ACT_LSB = 6;
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR = 12;
  localparam int SW_PG_N = 11;

  //----------------------------------------------------------------
  // Timing: timers count ticks of TICK_US microseconds
  //----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int TICK_US = 40;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_MS = 1000 / TICK_US;

  //----------------------------------------------------------------
  // Types
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_OFF = 3'h0,
    SEQ_ON_DLY = 3'h1,
    SEQ_RISE = 3'h2,
    SEQ_ON = 3'h3,
    SEQ_OFF_DLY = 3'h4,
    SEQ_FALL = 3'h5,
    SEQ_DECAY = 3'h6,
    SEQ_FAULT = 3'h7
  } pscm_seq_t;

  typedef struct packed {
    logic [1:0][15:0] ton_dly;
    logic [1:0][15:0] on_ramp;
    logic [1:0][15:0] ton_max;
    logic [1:0][7:0] ton_act;
    logic [1:0][15:0] toff_dly;
    logic [1:0][15:0] off_ramp;
    logic [1:0][15:0] toff_warn;
    logic [1:0][7:0] st_vout;
    logic [1:0][7:0] st_iout;
    logic [1:0][7:0] st_temp;
    logic [1:0][7:0] st_mfr;
    logic [7:0] st_input;
    logic [7:0] st_cml;
    pscm_seq_t [1:0] seq;
    logic [1:0][31:0] tmr;
    logic [1:0][31:0] flt_tmr;
    logic [1:0] flt_arm;
    logic [1:0] uv_seen;
    logic [9:0] pre;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    logic [1:0] rail_en;
    logic [1:0] rising;
    logic [1:0] falling;
    logic [1:0][15:0] cal_temp;
  } pscm_state_t;

  // Linear-11 milliseconds to timer ticks; negative mantissa gives 0
  function automatic logic [31:0] pscm_l11_ticks(input logic [15:0] v);
    logic [31:0] prod;
    logic [4:0] e;
    prod = 32'h0;
    e = v[15:11];
    if (!v[10]) begin
      prod = {22'h0, v[9:0]} * 32'(TICKS_PER_MS);
    end
    if (e[4]) begin
      pscm_l11_ticks = prod >> (5'(~e) + 5'h1);
    end else begin
      pscm_l11_ticks = prod << e;
    end
  endfunction : pscm_l11_ticks

endpackage : pscm_pkg

// ===== test/pscm_props.sv
`timescale 1ns/1ps
module pscm_props (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic [1:0] CH_ON_REQ_IN,
  input wire logic [31:0] TEMP_EXT_IN,
  input wire logic RSP_VALID_OUT,
  input wire logic RSP_ERR_OUT,
  input wire logic [15:0] RSP_DATA_OUT,
  input wire logic [1:0] RAIL_EN_OUT,
  input wire logic [1:0] RISING_OUT,
  input wire logic [1:0] FALLING_OUT,
  input wire logic [31:0] CAL_TEMP_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Answer timing, fixed values and ramp consistency
  property p_answer; CMD_VALID_IN |=> RSP_VALID_OUT; endproperty
  property p_quiet;
    !CMD_VALID_IN |=> !RSP_VALID_OUT && !RSP_ERR_OUT;
  endproperty
  property p_rev;
    CMD_VALID_IN && !CMD_WRITE_IN && CMD_CODE_IN == 8'h98
      |=> RSP_DATA_OUT == 16'h0022 && !RSP_ERR_OUT;
  endproperty
  property p_ceil;
    CMD_VALID_IN && !CMD_WRITE_IN && CMD_CODE_IN == 8'ha5
      |=> RSP_DATA_OUT == 16'he000;
  endproperty
  property p_ro;
    CMD_VALID_IN && CMD_WRITE_IN && CMD_CODE_IN inside {8'h88, 8'h8e}
      |=> RSP_ERR_OUT;
  endproperty
  property p_cal; 1'b1 |=> CAL_TEMP_OUT == $past(TEMP_EXT_IN); endproperty
  property p_ramp;
    (RISING_OUT & ~RAIL_EN_OUT) == 2'h0 && (RISING_OUT & FALLING_OUT) == 2'h0;
  endproperty
  property p_on;
    $rose(RAIL_EN_OUT[0]) |-> $past(CH_ON_REQ_IN[0], 2);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_rev: assert property (p_rev) else $error("bad revision");
  a_ceil: assert property (p_ceil) else $error("bad ceiling");
  a_ro: assert property (p_ro) else $error("read-only write taken");
  a_cal: assert property (p_cal) else $error("bad temp copy");
  a_ramp: assert property (p_ramp) else $error("bad ramp flags");
  a_on: assert property (p_on) else $error("rail without request");
  c_rev: cover property (CMD_VALID_IN && CMD_CODE_IN == 8'h98);
  c_rail: cover property ($rose(RAIL_EN_OUT[0]));
  c_err: cover property (RSP_ERR_OUT);
endmodule : pscm_props

bind pscm_top pscm_props i_pscm_props (.*);

// ===== test/pscm_host.sv
`timescale 1ns/1ps
module pscm_host (
  input wire logic clk_in,
  input wire logic rsp_valid_in,
  output logic valid_out,
  output logic write_out,
  output logic [7:0] page_out,
  output logic [7:0] code_out,
  output logic [4:0] index_out,
  output logic [15:0] wdata_out
);
  // Idle request lines
  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    {page_out, code_out, index_out, wdata_out} = 37'h0;
  end
  // One decoded transaction; page, code and write data inverted after use so none stays stale
  task automatic xfer(input logic w, input logic [7:0] pg, cd,
    input logic [4:0] ix, input logic [15:0] wd, output logic ok);
    @(negedge clk_in);
    {valid_out, write_out, page_out, code_out} = {1'b1, w, pg, cd};
    {index_out, wdata_out} = {ix, wd};
    @(negedge clk_in);
    valid_out = 1'b0;
    {page_out, code_out, wdata_out} = ~{page_out, code_out, wdata_out};
    ok = rsp_valid_in;
  endtask : xfer
endmodule : pscm_host

// ===== test/tb_pscm_top.sv
`timescale 1ns/1ps
module tb_pscm_top;
  logic CLK_IN, RST_B_IN, CMD_VALID_IN, CMD_WRITE_IN;
  logic RSP_VALID_OUT, RSP_ERR_OUT;
  logic [7:0] CMD_PAGE_IN, CMD_CODE_IN, EV_INPUT_IN = 8'h0, EV_CML_IN = 8'h0;
  logic [4:0] CMD_INDEX_IN;
  logic [15:0] CMD_WDATA_IN, RSP_DATA_OUT, EV_VOUT_IN = 16'h0;
  logic [15:0] EV_IOUT_IN = 16'h0, EV_TEMP_IN = 16'h0, EV_MFR_IN = 16'h0;
  logic [15:0] VIN_IN = 16'h1111, IIN_IN = 16'h2222;
  logic [15:0] TEMP_DIE_IN = 16'h3333, PIN_IN = 16'h4444;
  logic [31:0] VOUT_IN = 32'ha1a2a3a4, IOUT_IN = 32'hb1b2b3b4;
  logic [31:0] TEMP_EXT_IN = 32'hc1c2c3c4, FREQ_IN = 32'hd1d2d3d4;
  logic [31:0] POUT_IN = 32'he1e2e3e4, CAL_TEMP_OUT;
  logic [1:0] CH_ON_REQ_IN = 2'h0, VOUT_ABOVE_UV_IN = 2'h1;
  logic [1:0] VOUT_DECAYED_IN = 2'h0, RAIL_EN_OUT, RISING_OUT, FALLING_OUT;
  logic [15:0] dflt [7] = '{16'h8000, 16'hd200, 16'hd280, 16'h00b8,
    16'h8000, 16'hd200, 16'hf258};
  int n_mismatch = 0;
  int cmp_count = 0;

  pscm_top i_pscm_top (.*);
  pscm_host i_pscm_host (.clk_in(CLK_IN), .rsp_valid_in(RSP_VALID_OUT),
    .valid_out(CMD_VALID_IN), .write_out(CMD_WRITE_IN),
    .page_out(CMD_PAGE_IN), .code_out(CMD_CODE_IN),
    .index_out(CMD_INDEX_IN), .wdata_out(CMD_WDATA_IN));

  // Clock and hang guard
  initial begin
    CLK_IN = 1'b0;
    forever #20 CLK_IN = ~CLK_IN;
  end
  initial begin
    #4000000;
    n_mismatch++;
    report_and_stop();
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Bit 16 of the expectation is the error flag; response data is masked on writes
  task automatic io(input logic w, input logic [7:0] pg, cd,
    input logic [4:0] ix, input logic [15:0] wd, input logic [16:0] exp);
    logic ok;
    i_pscm_host.xfer(w, pg, cd, ix, wd, ok);
    chk({!ok || RSP_ERR_OUT, w ? 16'h0 : RSP_DATA_OUT}, exp);
  endtask : io
  task automatic rd(input logic [7:0] pg, cd, input logic [15:0] exp);
    io(1'b0, pg, cd, 5'h0, 16'h0, {1'b0, exp});
  endtask : rd
  task automatic wr(input logic [7:0] pg, cd, input logic [15:0] wd);
    io(1'b1, pg, cd, 5'h0, wd, 17'h0);
  endtask : wr
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    RST_B_IN = 1'b0;
    repeat (6) @(posedge CLK_IN);
    @(negedge CLK_IN);
    RST_B_IN = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i % 2), 8'h60 + 8'(i), dflt[i]);
    end
    wr(8'h00, 8'h63, 16'h0040);
    rd(8'h00, 8'h63, 16'h0040);
    rd(8'h01, 8'h63, 16'h00b8);
    rd(8'h00, 8'h88, VIN_IN);
    rd(8'h00, 8'h89, IIN_IN);
    rd(8'h01, 8'h8b, VOUT_IN[31:16]);
    rd(8'h00, 8'h8c, IOUT_IN[15:0]);
    rd(8'h01, 8'h95, FREQ_IN[31:16]);
    rd(8'h00, 8'h8d, TEMP_EXT_IN[15:0]);
    rd(8'h00, 8'h8e, TEMP_DIE_IN);
    rd(8'h01, 8'h96, POUT_IN[31:16]);
    rd(8'h00, 8'h97, PIN_IN);
    rd(8'h00, 8'h98, 16'h0022);
    rd(8'h01, 8'ha5, 16'he000);
    io(1'b0, 8'h00, 8'h99, 5'h0, 16'h0, 17'h00003);
    io(1'b0, 8'h00, 8'h99, 5'h1, 16'h0, 17'h00041);
    io(1'b0, 8'h00, 8'h9a, 5'h5, 16'h0, 17'h00031);
    io(1'b0, 8'h00, 8'h9a, 5'h6, 16'h0, 17'h00000);
    @(negedge CLK_IN);
    {EV_VOUT_IN, EV_IOUT_IN, EV_TEMP_IN, EV_MFR_IN} = 64'h0080800001000200;
    @(negedge CLK_IN);
    {EV_VOUT_IN, EV_IOUT_IN, EV_TEMP_IN, EV_MFR_IN} = 64'h0;
    rd(8'h00, 8'h7a, 16'h0080);
    rd(8'h01, 8'h7b, 16'h0080);
    rd(8'h01, 8'h7d, 16'h0001);
    rd(8'h01, 8'h80, 16'h0002);
    rd(8'h00, 8'h78, 16'h0060);
    rd(8'h00, 8'h79, 16'h8860);
    wr(8'h00, 8'h7a, 16'h0080);
    rd(8'h00, 8'h7a, 16'h0000);
    io(1'b1, 8'h00, 8'h88, 5'h0, 16'h0, 17'h10000);
    rd(8'h00, 8'h7e, 16'h0080);
    wr(8'h00, 8'h61, 16'hf801);
    wr(8'h01, 8'h62, 16'hf801);
    wr(8'hff, 8'h65, 16'hf801);
    wr(8'hff, 8'h66, 16'hf801);
    @(negedge CLK_IN);
    {CH_ON_REQ_IN, TEMP_EXT_IN} = {2'h3, 32'h0f0f5a5a};
    repeat (3) @(negedge CLK_IN);
    chk({RAIL_EN_OUT, RISING_OUT}, 17'hf);
    chk(CAL_TEMP_OUT[31:16], 17'h00f0f);
    repeat (10500) @(negedge CLK_IN);
    chk(RISING_OUT, 17'h3);
    repeat (3000) @(negedge CLK_IN);
    chk({RAIL_EN_OUT, RISING_OUT}, 17'h4);
    rd(8'h01, 8'h7a, 16'h0004);
    rd(8'h00, 8'h7a, 16'h0000);
    CH_ON_REQ_IN = 2'h0;
    repeat (3) @(negedge CLK_IN);
    chk({RAIL_EN_OUT[0], FALLING_OUT[0]}, 17'h3);
    repeat (13500) @(negedge CLK_IN);
    chk({RAIL_EN_OUT[0], FALLING_OUT[0]}, 17'h0);
    repeat (13000) @(negedge CLK_IN);
    rd(8'h00, 8'h7a, 16'h0002);
    report_and_stop();
  end
endmodule : tb_pscm_top
